// File: verilog/uscf_top.v
// Serial port status flags, frame control, transmitter, receiver and receive FIFO
// What this block does
// - Framing error flag set on badly framed character
// - Overrun sets flag, blocks further receive transfers
// - Status read then data access clears errors
// - Receiver idle low from start to stop
// - Receive-available set on transfer; interrupt if enabled
// - Error flags set with receive-available, same cycle
// - Receive-available clears after sequence, buffer empty
// - Transmit idle when empty, nothing sent; pin high
// - Transmit idle cleared by status read, data write
// - Transmit-empty set on load; sequence clears it
// - Transmitter enable sets transmit-empty
// - Global disable floats pins; else per-direction enables
// - Disable flushes buffers, resets baud counter
// - Disable clears enables, break, flags; sets idles
// - Disable aborts traffic; re-enable keeps configuration
// - Length select picks eight or nine bits
// - Parity generated and checked only when enabled
// - Parity type: one odd, zero even
// - Stop select picks one or two stops
// - Break after buffered data, low thirteen bits minimum
// - Ninth bit received read-only, transmitted write-only
// - Parity error flag on wrong received parity
// - Noise flag with receive-available, not on overrun
// - Data bits shifted least significant first
`timescale 1ns/100ps
`include "uscf_regs.vh"

// Small receive FIFO between receiver and the data register
module uscf_fifo #(
  parameter W = 9,
  parameter D = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1]; // Storage words
  reg [AW-1:0] wp_q; // Write pointer
  reg [AW-1:0] rp_q; // Read pointer
  reg [AW:0] cnt_q; // Fill level
  wire push;
  wire pop;
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage array has no reset; only pointers matter
  always @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers and level; flush drops everything
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // uscf_fifo

// Serial port core with its register port
module uscf_top (
  input wire core_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  input wire serial_in_pin,
  output wire serial_out_pin,
  output wire serial_out_pin_oe,
  output wire receive_irq
);
  localparam TX_IDLE = 3'b001;
  localparam TX_SEND = 3'b010;
  localparam TX_BRK = 3'b100;
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_BITS = 3'b100;

  // Control registers
  reg gen_q; // Global enable
  reg len9_q; // Nine data bits
  reg pen_q; // Parity enable
  reg podd_q; // Odd parity
  reg stop2_q; // Two stop bits
  reg brk_q; // Break request
  reg tx8_q; // Ninth transmit bit, write-only
  reg [7:0] ctrl2_q; // Second control register
  reg [7:0] baud_q; // Baud divisor
  reg [7:0] rdata_q; // Read data, registered
  // Status flags
  reg perr_q;
  reg nf_q;
  reg ferr_q;
  reg oerr_q;
  reg txif_q;
  reg arm_q; // Status read seen, awaiting data access
  reg arm_rx_q; // Status read saw receive-available
  reg arm_tx_q; // Status read saw transmit-empty
  reg txen_prev_q; // Edge detect for transmitter enable
  // Baud and machines
  reg [7:0] bcnt_q;
  reg [2:0] tx_st_q;
  reg [3:0] tx_os_q;
  reg [3:0] tx_left_q;
  reg [12:0] tx_sh_q;
  reg [8:0] hold_q; // Transmit data register
  reg pend_q; // Transmit data register full
  reg [2:0] rx_st_q;
  reg [3:0] rx_os_q;
  reg [3:0] rx_idx_q;
  reg [11:0] rx_bits_q; // Room for nine data, parity and two stops
  reg rx_a_q;
  reg rx_b_q;
  reg rx_nz_q;
  reg [2:0] rx_sync_q; // Three-stage pin synchroniser
  reg rx_line_q; // Filtered line level
  reg rx_done_q; // Frame complete pulse
  reg [12:0] tx_frame;

  wire txen = ctrl2_q[`USCF_C2_TXEN];
  wire rxen = ctrl2_q[`USCF_C2_RXEN];
  wire st_rd = reg_rd & (reg_addr == `USCF_IDX_STATUS);
  wire dat_rd = reg_rd & (reg_addr == `USCF_IDX_DATA);
  wire dat_wr = reg_wr & (reg_addr == `USCF_IDX_DATA);
  wire dat_acc = dat_rd | dat_wr;
  wire fr_wr = reg_wr & (reg_addr == `USCF_IDX_FRAME);
  wire dis_evt = fr_wr & ~reg_wdata[`USCF_FR_GEN] & gen_q;
  // Disable write resets both sides at once, so idles read set right after it
  wire tx_clr = ~gen_q | ~txen | dis_evt;
  wire rx_clr = ~gen_q | ~rxen | dis_evt;
  wire os_tick = gen_q & (bcnt_q == baud_q);
  wire [3:0] nd = len9_q ? 4'd9 : 4'd8;
  wire [3:0] nbits = nd + {3'b000, pen_q} + (stop2_q ? 4'd2 : 4'd1);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_out_data;
  wire [8:0] rx_word = len9_q ? rx_bits_q[8:0] : {1'b0, rx_bits_q[7:0]};
  wire rx_par = rx_bits_q[nd];
  wire rx_stop = rx_bits_q[nd + {3'b000, pen_q}];
  wire rx_perr = pen_q & ((^rx_word) ^ rx_par ^ podd_q);
  wire rx_ferr = ~rx_stop;
  wire push = rx_done_q & ~rx_clr & ~oerr_q & fifo_in_ready;
  wire ovr = rx_done_q & ~rx_clr & (oerr_q | ~fifo_in_ready);
  wire pop = dat_rd & arm_rx_q;
  wire rxif = fifo_out_valid;
  wire ridle = (rx_st_q == RX_IDLE);
  wire tidle = txif_q & ~pend_q & (tx_st_q == TX_IDLE);
  wire [7:0] status = {perr_q, nf_q, ferr_q, oerr_q, ridle, rxif, tidle, txif_q};
  wire rx_maj = (rx_a_q & rx_b_q) | (rx_a_q & rx_line_q) | (rx_b_q & rx_line_q);
  wire rx_noise = ~((rx_a_q == rx_b_q) & (rx_b_q == rx_line_q));
  integer i;

  assign reg_rdata = rdata_q;
  assign receive_irq = ctrl2_q[`USCF_C2_RIE] & rxif;
  assign serial_out_pin_oe = gen_q & txen;
  assign serial_out_pin = (tx_st_q == TX_SEND) ? tx_sh_q[0] : ~(tx_st_q == TX_BRK);

  // Receive FIFO; flushed whenever the receiver is off
  uscf_fifo #(
    .W(9),
    .D(`USCF_RXFIFO_DEPTH),
    .AW(2)
  ) u_rxfifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(rx_clr | dis_evt),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Transmit frame: start, data LSB first, parity, stops as ones
  always @* begin
    tx_frame = 13'h1fff;
    tx_frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < nd) begin
        tx_frame[i+1] = hold_q[i];
      end
    end
    if (pen_q) begin
      tx_frame[nd+1] = (^(len9_q ? hold_q : {1'b0, hold_q[7:0]})) ^ podd_q;
    end
  end

  // Register writes and readback; disable also clears enables and break
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gen_q <= 1'b0;
      len9_q <= 1'b0;
      pen_q <= 1'b0;
      podd_q <= 1'b0;
      stop2_q <= 1'b0;
      brk_q <= 1'b0;
      tx8_q <= 1'b0;
      ctrl2_q <= `USCF_CTRL2_RST;
      baud_q <= `USCF_BAUD_RST;
      rdata_q <= 8'h00;
    end else begin
      if (fr_wr) begin
        gen_q <= reg_wdata[`USCF_FR_GEN];
        len9_q <= reg_wdata[`USCF_FR_LEN9];
        pen_q <= reg_wdata[`USCF_FR_PEN];
        podd_q <= reg_wdata[`USCF_FR_PODD];
        stop2_q <= reg_wdata[`USCF_FR_STOP2];
        brk_q <= reg_wdata[`USCF_FR_BRK] & reg_wdata[`USCF_FR_GEN];
        tx8_q <= reg_wdata[`USCF_FR_TX8];
      end
      if (dis_evt) begin
        ctrl2_q[`USCF_C2_TXEN] <= 1'b0;
        ctrl2_q[`USCF_C2_RXEN] <= 1'b0;
      end else if (reg_wr & (reg_addr == `USCF_IDX_CTRL2)) begin
        ctrl2_q <= reg_wdata;
      end
      if (reg_wr & (reg_addr == `USCF_IDX_BAUD)) begin
        baud_q <= reg_wdata;
      end
      if (reg_rd) begin
        case (reg_addr)
          `USCF_IDX_STATUS: rdata_q <= status;
          // Ninth received bit read-only, ninth transmit bit reads zero
          `USCF_IDX_FRAME: rdata_q <= {gen_q, len9_q, pen_q, podd_q, stop2_q, brk_q,
                                       fifo_out_data[8], 1'b0};
          `USCF_IDX_CTRL2: rdata_q <= ctrl2_q;
          `USCF_IDX_DATA: rdata_q <= fifo_out_data[7:0];
          `USCF_IDX_BAUD: rdata_q <= baud_q;
          default: rdata_q <= 8'h00; // Unmapped reads zero
        endcase
      end
    end
  end

  // Error flags and clear sequence; a new set beats a same-cycle clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      perr_q <= 1'b0;
      nf_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
      arm_q <= 1'b0;
      arm_rx_q <= 1'b0;
      arm_tx_q <= 1'b0;
    end else if (dis_evt | ~gen_q) begin
      perr_q <= 1'b0;
      nf_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
      arm_q <= 1'b0;
      arm_rx_q <= 1'b0;
      arm_tx_q <= 1'b0;
    end else begin
      if (st_rd) begin
        arm_q <= 1'b1;
        arm_rx_q <= rxif;
        arm_tx_q <= txif_q;
      end else if (dat_acc) begin
        arm_q <= 1'b0;
        arm_rx_q <= 1'b0;
        arm_tx_q <= 1'b0;
      end
      // Errors land with the word, same edge as receive-available
      if (push & rx_perr) begin
        perr_q <= 1'b1;
      end else if (dat_acc & arm_q) begin
        perr_q <= 1'b0;
      end
      if (push & rx_nz_q) begin
        nf_q <= 1'b1;
      end else if (dat_acc & arm_q) begin
        nf_q <= 1'b0;
      end
      if (push & rx_ferr) begin
        ferr_q <= 1'b1;
      end else if (dat_acc & arm_q) begin
        ferr_q <= 1'b0;
      end
      if (ovr) begin
        oerr_q <= 1'b1;
      end else if (dat_acc & arm_q) begin
        oerr_q <= 1'b0;
      end
    end
  end

  // Oversample divider; held at zero while disabled
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bcnt_q <= 8'h00;
    end else if (~gen_q | os_tick) begin
      bcnt_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_q + 8'h01;
    end
  end

  // Transmit data register and empty flag
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txif_q <= 1'b1;
      pend_q <= 1'b0;
      hold_q <= 9'h000;
      txen_prev_q <= 1'b0;
    end else begin
      txen_prev_q <= txen & gen_q;
      if (tx_clr) begin
        txif_q <= 1'b1;
        pend_q <= 1'b0;
      end else if ((tx_st_q == TX_IDLE) & pend_q) begin
        txif_q <= 1'b1;
        pend_q <= 1'b0;
      end else if (~txen_prev_q) begin
        txif_q <= 1'b1;
      end else if (dat_wr & arm_tx_q) begin
        txif_q <= 1'b0;
        pend_q <= 1'b1;
      end
      if (dat_wr) begin
        hold_q <= {tx8_q, reg_wdata};
      end
    end
  end

  // Transmitter: frame shifting and break
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q <= 13'h1fff;
    end else if (tx_clr) begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q <= 13'h1fff;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_os_q <= 4'h0;
          if (pend_q) begin
            tx_sh_q <= tx_frame;
            tx_left_q <= nbits + 4'd1;
            tx_st_q <= TX_SEND;
          end else if (brk_q) begin
            tx_left_q <= 4'h0;
            tx_st_q <= TX_BRK;
          end
        end
        TX_SEND: begin
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == `USCF_OS_LAST) begin
              tx_sh_q <= {1'b1, tx_sh_q[12:1]};
              tx_left_q <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h1) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        TX_BRK: begin
          // Counts whole bit times, saturating at the minimum length
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if ((tx_os_q == `USCF_OS_LAST) & (tx_left_q != `USCF_BREAK_BITS)) begin
              tx_left_q <= tx_left_q + 4'h1;
            end
          end
          if ((tx_left_q == `USCF_BREAK_BITS) & ~brk_q) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_sync_q <= 3'b111;
      rx_line_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], serial_in_pin};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_line_q <= rx_sync_q[2];
      end
    end
  end

  // Receiver: three mid-bit samples, majority vote, noise on disagreement
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_bits_q <= 12'h000;
      rx_a_q <= 1'b1;
      rx_b_q <= 1'b1;
      rx_nz_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else if (rx_clr) begin
      rx_st_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_nz_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          rx_os_q <= 4'h0;
          if (~rx_line_q) begin
            rx_nz_q <= 1'b0;
            rx_st_q <= RX_START;
          end
        end
        RX_START, RX_BITS: begin
          if (os_tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `USCF_OS_S1) begin
              rx_a_q <= rx_line_q;
            end
            if (rx_os_q == `USCF_OS_S2) begin
              rx_b_q <= rx_line_q;
            end
            if (rx_os_q == `USCF_OS_S3) begin
              if (rx_noise) begin
                rx_nz_q <= 1'b1;
              end
              if (rx_st_q == RX_START) begin
                if (rx_maj) begin
                  rx_st_q <= RX_IDLE; // False start, glitch rejected
                end
              end else begin
                rx_bits_q[rx_idx_q] <= rx_maj;
              end
            end
            if (rx_os_q == `USCF_OS_LAST) begin
              if (rx_st_q == RX_START) begin
                rx_idx_q <= 4'h0;
                rx_st_q <= RX_BITS;
              end else if (rx_idx_q == nbits - 4'd1) begin
                rx_done_q <= 1'b1;
                rx_st_q <= RX_IDLE;
              end else begin
                rx_idx_q <= rx_idx_q + 4'h1;
              end
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
endmodule // uscf_top

// File: verilog/uscf_regs.vh
// Register indices, field positions, reset values and timing counts of the serial port
`ifndef USCF_REGS_VH
`define USCF_REGS_VH
`define USCF_IDX_STATUS 3'h0
`define USCF_IDX_FRAME 3'h1
`define USCF_IDX_CTRL2 3'h2
`define USCF_IDX_DATA 3'h3
`define USCF_IDX_BAUD 3'h4
`define USCF_FR_GEN 7
`define USCF_FR_LEN9 6
`define USCF_FR_PEN 5
`define USCF_FR_PODD 4
`define USCF_FR_STOP2 3
`define USCF_FR_BRK 2
`define USCF_FR_TX8 0
`define USCF_C2_TXEN 7
`define USCF_C2_RXEN 6
`define USCF_C2_RIE 2
`define USCF_FRAME_RST 8'h00
`define USCF_CTRL2_RST 8'h00
`define USCF_BAUD_RST 8'h00
`define USCF_OS_LAST 4'hf
`define USCF_OS_S1 4'h7
`define USCF_OS_S2 4'h8
`define USCF_OS_S3 4'h9
`define USCF_BREAK_BITS 4'hd
`define USCF_RXFIFO_DEPTH 4
`endif

// File: tb/uscf_top_asserts.sv
// Checker on the serial port's register and pin ports
`timescale 1ns/100ps
`include "uscf_regs.vh"
module uscf_top_asserts (
  input wire core_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire serial_in_pin,
  input wire serial_out_pin,
  input wire serial_out_pin_oe,
  input wire receive_irq
);
  reg [7:2] frm_q; // Shadow of frame control, upper bits
  reg txen_q; // Shadow of transmitter enable
  reg rie_q; // Shadow of receive interrupt enable
  wire st_rd; // Status read strobe
  assign st_rd = reg_rd && reg_addr == `USCF_IDX_STATUS;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow follows writes; disable drops enable and break
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frm_q <= 6'h00;
      txen_q <= 1'b0;
      rie_q <= 1'b0;
    end else if (reg_wr && reg_addr == `USCF_IDX_FRAME) begin
      frm_q <= {reg_wdata[7:3], reg_wdata[2] & reg_wdata[7]};
      if (!reg_wdata[7] && frm_q[7]) txen_q <= 1'b0;
    end else if (reg_wr && reg_addr == `USCF_IDX_CTRL2) begin
      txen_q <= reg_wdata[7];
      rie_q <= reg_wdata[2];
    end
  end
  oe_follows_a: assert property (serial_out_pin_oe == (frm_q[7] && txen_q))
    else $error("pin enable does not follow enables");
  float_idle_a: assert property (!serial_out_pin_oe |-> serial_out_pin)
    else $error("undriven transmit level not high");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (!rie_q |-> !receive_irq)
    else $error("interrupt while masked");
  irq_flag_a: assert property (st_rd && rie_q |=> reg_rdata[2] == $past(receive_irq))
    else $error("interrupt differs from receive flag");
  frame_hold_a: assert property (reg_rd && reg_addr == `USCF_IDX_FRAME
    |=> reg_rdata[0] == 1'b0 && reg_rdata[7:2] == $past(frm_q))
    else $error("frame control readback wrong");
  off_status_a: assert property (st_rd && !frm_q[7] |=> reg_rdata == 8'h0b)
    else $error("status wrong while disabled");
  idle_empty_a: assert property (st_rd |=> !reg_rdata[1] || reg_rdata[0])
    else $error("transmit idle without empty");
  idle_pin_a: assert property (st_rd |=> !reg_rdata[1] || $past(serial_out_pin))
    else $error("transmit idle with low pin");
  ctrl2_txen_a: assert property (reg_rd && reg_addr == `USCF_IDX_CTRL2
    |=> reg_rdata[7] == $past(txen_q))
    else $error("transmitter enable readback wrong");
endmodule // uscf_top_asserts
bind uscf_top uscf_top_asserts chk_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe(serial_out_pin_oe), .receive_irq(receive_irq));

// File: tb/uscf_peer.sv
// Far-side serial device: frame sender and frame sampler
`timescale 1ns/100ps
module uscf_peer (
  input wire core_clk,
  input wire line_out,
  input wire line_oe,
  output reg line_in
);
  reg last_q; // Last driven transmit level
  wire seen; // Transmit wire as seen here
  integer k;
  integer t;
  // No pull-up assumed, so a floating wire shows the inverse
  assign seen = line_oe ? line_out : ~last_q;
  always @(posedge core_clk) begin
    if (line_oe) last_q <= line_out;
  end
  initial begin
    line_in = 1'b1;
    last_q = 1'b1;
  end
  // One frame, first bit first, sixteen clocks a bit
  // Glitch lasts two clocks so it passes the pin filter but sways one vote only
  task send(input [13:0] v, input glitch);
    for (k = 0; k < 14; k = k + 1) begin
      for (t = 0; t < 16; t = t + 1) begin
        @(negedge core_clk);
        line_in = (glitch && k == 3 && (t == 10 || t == 11)) ? ~v[k] : v[k];
      end
    end
  endtask
  // Wait for start, then sample mid-bit; zeros if no start comes
  task grab(output [13:0] v);
    v = 14'h0000;
    t = 0;
    while (seen && t < 600) begin
      @(negedge core_clk);
      t = t + 1;
    end
    repeat (8) @(negedge core_clk);
    for (k = 0; k < 14; k = k + 1) begin
      v[k] = (t < 600) ? seen : 1'b0;
      repeat (16) @(negedge core_clk);
    end
  endtask
endmodule // uscf_peer

// File: tb/uart_status_and_frame_control_bench.sv
// Self-checking bench of the serial port core
`timescale 1ns/100ps
module uart_status_and_frame_control_bench;
  reg core_clk;
  reg rst;
  reg [2:0] reg_addr;
  reg reg_wr;
  reg reg_rd;
  reg [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire serial_in_pin;
  wire serial_out_pin;
  wire serial_out_pin_oe;
  wire receive_irq;
  integer n_fail;
  integer checked;
  integer cyc; // Cycle count for the hang guard
  integer seed;
  integer i;
  integer e; // Error kind injected into a received frame
  reg [3:0] c; // Length, parity, odd, two stops
  reg [8:0] d;
  reg [8:0] q [0:4];
  reg [7:0] s;
  reg [13:0] v;
  reg [13:0] g;
  uscf_top DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe(serial_out_pin_oe), .receive_irq(receive_irq));
  uscf_peer peer (.core_clk(core_clk), .line_out(serial_out_pin),
    .line_oe(serial_out_pin_oe), .line_in(serial_in_pin));
  // Expected frame bits; unused tail stays high as idle
  function [13:0] frm(input [8:0] dd, input [3:0] cc);
    integer j;
    begin
      frm = 14'h3fff;
      frm[0] = 1'b0;
      for (j = 0; j < 8 + cc[3]; j = j + 1) frm[j + 1] = dd[j];
      if (cc[2]) frm[9 + cc[3]] = ^(dd & {cc[3], 8'hff}) ^ cc[1];
    end
  endfunction
  task chk(input string nm, input [15:0] ex, input [15:0] got);
    checked = checked + 1;
    if (got !== ex) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Strobes change at falling edges and last one cycle
  task wr(input [2:0] a, input [7:0] w);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task rd(input [2:0] a, output [7:0] r);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    r = reg_rdata;
  endtask
  task close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    {n_fail, checked, cyc} = 0;
    seed = 32'h4e64;
    {rst, reg_wr, reg_rd} = 3'b100;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    rd(3'h0, s);
    chk("reset status", 8'h0b, s);
    chk("reset pins", 2'b10, {serial_out_pin, serial_out_pin_oe});
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hc4);
    wr(3'h1, 8'h80);
    rd(3'h0, s);
    chk("enabled status", 8'h0b, s);
    wr(3'h5, 8'hff);
    rd(3'h5, s);
    chk("unmapped", 8'h00, s);
    $display("setup done");
    // Every frame format, random data, sampled on the wire
    for (i = 0; i < 16; i = i + 1) begin
      c = i;
      d = $random(seed);
      wr(3'h1, {1'b1, c, 2'b00, d[8]});
      rd(3'h0, s);
      wr(3'h3, d[7:0]);
      fork
        peer.grab(g);
        rd(3'h0, s);
      join
      chk("sending flags", 2'b01, s[1:0]);
      chk("tx frame", frm(d & {c[3], 8'hff}, c), g);
    end
    rd(3'h0, s);
    chk("tx idle", 2'b11, s[1:0]);
    $display("transmit done");
    // Every format received; last three carry parity, stop, glitch faults
    for (i = 0; i < 16; i = i + 1) begin
      c = i;
      d = $random(seed);
      e = (i > 12) ? i - 12 : 0;
      wr(3'h1, {1'b1, c, 3'b000});
      v = frm(d, c);
      if (e == 1) v[9 + c[3]] = ~v[9 + c[3]];
      if (e == 2) v[9 + c[3] + c[2]] = 1'b0;
      fork
        peer.send(v, e == 3);
        begin
          repeat (60) @(negedge core_clk);
          rd(3'h0, s);
          chk("rx busy", 1'b0, s[3]);
        end
      join
      rd(3'h0, s);
      chk("rx status", {e == 1, e == 3, e == 2, 5'h0f}, s);
      chk("irq", 1'b1, receive_irq);
      rd(3'h1, s);
      chk("ninth bit", c[3] & d[8], s[1]);
      rd(3'h3, s);
      chk("rx data", d[7:0], s);
      rd(3'h0, s);
      chk("rx cleared", 8'h0b, s);
    end
    $display("receive done");
    wr(3'h1, 8'h80);
    for (i = 0; i < 5; i = i + 1) begin
      q[i] = $random(seed);
      peer.send(frm(q[i], 4'h0), 1'b0);
    end
    rd(3'h0, s);
    chk("overrun status", 8'h1f, s);
    // Each pop needs its own status read with the flag set
    for (i = 0; i < 4; i = i + 1) begin
      rd(3'h0, s);
      chk("fifo filled", 1'b1, s[2]);
      rd(3'h3, s);
      chk("kept data", q[i][7:0], s);
    end
    rd(3'h0, s);
    chk("drained", 8'h0b, s);
    $display("overrun done");
    wr(3'h1, 8'h84);
    repeat (4) @(negedge core_clk);
    e = 0;
    for (i = 0; i < 250; i = i + 1) begin
      @(negedge core_clk);
      if (serial_out_pin !== 1'b0) e = e + 1;
    end
    chk("break gaps", 16'h0000, e[15:0]);
    chk("break low", 1'b0, serial_out_pin);
    rd(3'h0, s);
    chk("break busy", 1'b0, s[1]);
    wr(3'h1, 8'h80);
    repeat (40) @(negedge core_clk);
    chk("break end", 1'b1, serial_out_pin);
    // Short request: line stays low for the minimum length anyway
    wr(3'h1, 8'h84);
    wr(3'h1, 8'h80);
    repeat (150) @(negedge core_clk);
    chk("break minimum", 1'b0, serial_out_pin);
    repeat (100) @(negedge core_clk);
    chk("break released", 1'b1, serial_out_pin);
    $display("break done");
    peer.send(frm(9'h0a5, 4'h0), 1'b0);
    fork
      peer.send(frm(9'h05a, 4'h0), 1'b0);
      begin
        repeat (70) @(negedge core_clk);
        wr(3'h1, 8'h58);
      end
    join
    rd(3'h0, s);
    chk("off status", 8'h0b, s);
    rd(3'h2, s);
    chk("off ctrl2", 8'h04, s);
    chk("off pin", 1'b0, serial_out_pin_oe);
    wr(3'h1, 8'hd8);
    rd(3'h1, s);
    chk("kept config", 8'hd8, s);
    rd(3'h0, s);
    chk("flushed", 8'h0b, s);
    $display("disable done");
    close_out;
  end
endmodule // uart_status_and_frame_control_bench
